// ### adc_readout_consts.svh
// Constants of the ADC serial readout interface: timing, widths, frame lengths.
// Assumes the core clock period given here matches the clock fed to the block.
`ifndef ADC_READOUT_CONSTS_SVH
`define ADC_READOUT_CONSTS_SVH

// ---------------------------------------------------------------
// Clocking
// ---------------------------------------------------------------
`define CORE_CLK_PERIOD_NS 10

// ---------------------------------------------------------------
// Conversion timing (ns); plain defaults, tune per process
// ---------------------------------------------------------------
`define CONV_TIME_MIN_NS 500
`define CONV_TIME_MAX_NS 2200
`define CONV_TIME_DEF_NS 1600

// ---------------------------------------------------------------
// Result and frame lengths
// ---------------------------------------------------------------
`define RESULT_BITS 16
`define FRAME_EDGES_PLAIN 5'h10
`define FRAME_EDGES_IND 5'h11
`define EDGE_CNT_W 5
`define SCK_GRAY_W 4

`endif

// ### adc_readout_pkg.sv
// Types shared by the ADC serial readout interface.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package adc_readout_pkg;

  // ---------------------------------------------------------------
  // Readout sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACQUIRE,
    ST_CONVERT,
    ST_READY,
    ST_SHIFT
  } state_e;

  // ---------------------------------------------------------------
  // Interface mode picked at the convert-start edge
  // ---------------------------------------------------------------
  typedef enum logic {
    MODE_CHIP_SELECT,
    MODE_CHAIN
  } iface_mode_e;

endpackage : adc_readout_pkg

// ### level_sync.sv
// Two-flop synchroniser for a bundle of levels into the core clock.
// Assumes each bit may change at any time; multi-bit values must be gray coded.
`timescale 1ns/100ps

module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // Destination clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous levels
  output logic [WIDTH-1:0] q // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("level_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds the second stage only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : level_sync

// ### adc_serial_readout_iface.sv
// Conversion control and chip-select serial readout of a 16-bit SAR converter.
// Assumes pins convert_start and serial_in_select are asynchronous to clock,
// serial_clock comes from the host and may stop between frames, and
// sample_code is settled by the analog core in the clock domain.
`timescale 1ns/100ps
`include "adc_readout_consts.svh"

// Overview of operation
// - Serial input at convert rise picks mode
// - Tied inputs resolve to chain mode
// - Optional start bit flags conversion done
// - Chip-select: flag if selected at end
// - Chain: flag if serial clock high
// - Rise with input high starts, floats output
// - Conversion ignores later convert-start changes
// - Return to acquisition, power down after
// - Select fall drives MSB, falls shift
// - Plain frame floats at 16th fall
// - Flag frame floats during conversion
// - Completion with flag drives output low; chain mode leaves it floating
// - After flag, MSB first on falls
// - Flag frame floats at 17th fall
// - Three-wire ties input high; four-wire selects
// - Sample taken on convert-start rising edge
module adc_serial_readout_iface #(
  parameter int CONV_TIME_NS = `CONV_TIME_DEF_NS, // Conversion duration
  parameter int GRAY_W = `SCK_GRAY_W // Width of the edge count crossing
) (
  input wire logic clock, // Core clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic serial_clock, // Host serial clock, link domain
  input wire logic convert_start, // Convert-start pin
  input wire logic serial_in_select, // Serial input / read select pin
  input wire logic [`RESULT_BITS-1:0] sample_code, // Code from the analog core
  output logic serial_out, // Serial output data
  output logic serial_out_oe, // High while serial_out is driven
  output logic sample_hold, // One-cycle pulse: input held
  output logic converting, // High during conversion phase
  output logic powered_down, // High in acquisition, core powered down
  output logic conv_done, // One-cycle pulse at conversion end
  output logic chain_mode, // Mode latched at last start, 1 = chain
  output logic done_flag_en // Start bit enabled for this result
);

  // ---------------------------------------------------------------
  // Timing derived from the core clock
  // ---------------------------------------------------------------
  localparam int CLK_NS = `CORE_CLK_PERIOD_NS;
  localparam int MIN_CYCLES = (`CONV_TIME_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_CYCLES = `CONV_TIME_MAX_NS / CLK_NS;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = $clog2(CONV_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(CONV_CYCLES - 1);
  localparam int RB = `RESULT_BITS;
  localparam int EW = `EDGE_CNT_W;

  generate
    if (CONV_CYCLES < MIN_CYCLES || CONV_CYCLES > MAX_CYCLES) begin : g_bad_conv
      $error("adc_serial_readout_iface: CONV_TIME_NS outside conversion window");
    end
    if (GRAY_W < 2) begin : g_bad_gray
      $error("adc_serial_readout_iface: GRAY_W must be at least 2");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Gray helpers
  // ---------------------------------------------------------------
  function automatic logic [GRAY_W-1:0] bin2gray(input logic [GRAY_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [GRAY_W-1:0] gray2bin(input logic [GRAY_W-1:0] g);
    logic [GRAY_W-1:0] b;
    b = '0;
    b[GRAY_W-1] = g[GRAY_W-1];
    for (int i = GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  // ---------------------------------------------------------------
  // Link domain: count serial clock falling edges
  // ---------------------------------------------------------------
  // The gray count and the raw clock level cross; a stopped clock just freezes the count,
  // so nothing here waits for an edge outside a frame.
  logic [GRAY_W-1:0] sck_bin_q;
  logic [GRAY_W-1:0] sck_gray_q;

  always_ff @(negedge serial_clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_bin_q <= '0;
      sck_gray_q <= '0;
    end else begin
      sck_bin_q <= sck_bin_q + 1'b1;
      sck_gray_q <= bin2gray(sck_bin_q + 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // Crossing into the core clock
  // ---------------------------------------------------------------
  logic cnv_s;
  logic sdi_s;
  logic sck_s;
  logic [GRAY_W-1:0] gray_s;

  level_sync #(
    .WIDTH(GRAY_W + 3)
  ) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .d({convert_start, serial_in_select, serial_clock, sck_gray_q}),
    .q({cnv_s, sdi_s, sck_s, gray_s})
  );

  // ---------------------------------------------------------------
  // Edge detection on synchronised pins
  // ---------------------------------------------------------------
  logic cnv_prev_q;
  logic sdi_prev_q;
  logic [GRAY_W-1:0] fall_cnt_q;
  logic cnv_rise;
  logic sel_now;
  logic sel_prev;
  logic sel_fall;
  logic desel;
  logic sck_fall;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnv_prev_q <= 1'b0;
      sdi_prev_q <= 1'b1;
      fall_cnt_q <= '0;
    end else begin
      cnv_prev_q <= cnv_s;
      sdi_prev_q <= sdi_s;
      fall_cnt_q <= gray2bin(gray_s);
    end
  end

  assign cnv_rise = cnv_s & ~cnv_prev_q;
  // Read select merge
  // Three-wire ties the input high so convert-start low selects; four-wire
  // holds convert-start high and the serial input low selects.
  assign sel_now = ~(cnv_s & sdi_s);
  assign sel_prev = ~(cnv_prev_q & sdi_prev_q);
  assign sel_fall = sel_now & ~sel_prev;
  assign desel = ~sel_now & sel_prev;
  // At most one link edge lands per core cycle at the bench rates
  assign sck_fall = (gray2bin(gray_s) != fall_cnt_q);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  adc_readout_pkg::state_e state_q;
  logic [TMR_W-1:0] timer_q;
  logic conv_end;
  logic [EW-1:0] edge_cnt_q;
  logic [EW-1:0] edge_limit;
  logic frame_last;
  logic ind_q;
  adc_readout_pkg::iface_mode_e mode_q;
  logic chain_ind_q;

  assign conv_end = (state_q == adc_readout_pkg::ST_CONVERT) && (timer_q == '0);
  assign edge_limit = ind_q ? `FRAME_EDGES_IND : `FRAME_EDGES_PLAIN;
  assign frame_last = sck_fall && (edge_cnt_q == edge_limit - 1'b1);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= adc_readout_pkg::ST_ACQUIRE;
    end else begin
      unique case (state_q)
        adc_readout_pkg::ST_ACQUIRE: begin
          if (cnv_rise) begin
            state_q <= adc_readout_pkg::ST_CONVERT;
          end
        end
        adc_readout_pkg::ST_CONVERT: begin
          if (conv_end) begin
            if (mode_q == adc_readout_pkg::MODE_CHAIN) begin
              state_q <= adc_readout_pkg::ST_ACQUIRE;
            end else if (sel_now) begin
              state_q <= adc_readout_pkg::ST_SHIFT;
            end else begin
              state_q <= adc_readout_pkg::ST_READY;
            end
          end
        end
        adc_readout_pkg::ST_READY: begin
          if (cnv_rise) begin
            state_q <= adc_readout_pkg::ST_CONVERT;
          end else if (sel_fall) begin
            state_q <= adc_readout_pkg::ST_SHIFT;
          end
        end
        adc_readout_pkg::ST_SHIFT: begin
          // Float at last edge or deselect
          if (cnv_rise) begin
            state_q <= adc_readout_pkg::ST_CONVERT;
          end else if (desel || frame_last) begin
            state_q <= adc_readout_pkg::ST_ACQUIRE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Conversion timer on internal timing
  // ---------------------------------------------------------------
  // Configurable duration
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer_q <= '0;
    end else if (state_q != adc_readout_pkg::ST_CONVERT && cnv_rise) begin
      timer_q <= TMR_LOAD;
    end else if (state_q == adc_readout_pkg::ST_CONVERT && timer_q != '0) begin
      timer_q <= timer_q - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Mode and indicator selection
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= adc_readout_pkg::MODE_CHIP_SELECT;
      chain_ind_q <= 1'b0;
    end else if (state_q != adc_readout_pkg::ST_CONVERT && cnv_rise) begin
      // Level before the edge
      // Sampling the input one cycle before the rise models its hold
      // requirement: an input tied to convert-start reads low here.
      mode_q <= sdi_prev_q ? adc_readout_pkg::MODE_CHIP_SELECT :
                             adc_readout_pkg::MODE_CHAIN;
      chain_ind_q <= sck_s;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ind_q <= 1'b0;
    end else if (conv_end) begin
      ind_q <= (mode_q == adc_readout_pkg::MODE_CHAIN) ? chain_ind_q : sel_now;
    end
  end

  // ---------------------------------------------------------------
  // Result capture and output shifter
  // ---------------------------------------------------------------
  logic [RB-1:0] code_q;
  logic [RB:0] shreg_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      code_q <= '0;
    end else if (state_q != adc_readout_pkg::ST_CONVERT && cnv_rise) begin
      code_q <= sample_code;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shreg_q <= '0;
      edge_cnt_q <= '0;
    end else if (conv_end && mode_q == adc_readout_pkg::MODE_CHIP_SELECT && sel_now) begin
      shreg_q <= {1'b0, code_q};
      edge_cnt_q <= '0;
    end else if (state_q == adc_readout_pkg::ST_READY && sel_fall && !cnv_rise) begin
      shreg_q <= {code_q, 1'b0};
      edge_cnt_q <= '0;
    end else if (state_q == adc_readout_pkg::ST_SHIFT && sck_fall) begin
      shreg_q <= {shreg_q[RB-1:0], 1'b0};
      edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Serial output driver
  // ---------------------------------------------------------------
  logic drive_next;
  logic data_next;

  always_comb begin
    drive_next = 1'b0;
    data_next = 1'b0;
    unique case (state_q)
      adc_readout_pkg::ST_ACQUIRE: begin
        drive_next = 1'b0;
      end
      adc_readout_pkg::ST_CONVERT: begin
        if (conv_end && mode_q == adc_readout_pkg::MODE_CHIP_SELECT && sel_now) begin
          drive_next = 1'b1;
          data_next = 1'b0;
        end
      end
      adc_readout_pkg::ST_READY: begin
        if (sel_fall && !cnv_rise) begin
          drive_next = 1'b1;
          data_next = code_q[RB-1];
        end
      end
      adc_readout_pkg::ST_SHIFT: begin
        if (cnv_rise || desel || frame_last) begin
          drive_next = 1'b0;
        end else begin
          drive_next = 1'b1;
          data_next = sck_fall ? shreg_q[RB-1] : shreg_q[RB];
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out <= data_next;
      serial_out_oe <= drive_next;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sample_hold <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      sample_hold <= (state_q != adc_readout_pkg::ST_CONVERT) && cnv_rise;
      conv_done <= conv_end;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      converting <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      converting <= (state_q == adc_readout_pkg::ST_CONVERT) && !conv_end;
      powered_down <= (state_q != adc_readout_pkg::ST_CONVERT) || conv_end;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chain_mode <= 1'b0;
      done_flag_en <= 1'b0;
    end else begin
      chain_mode <= (mode_q == adc_readout_pkg::MODE_CHAIN);
      done_flag_en <= ind_q;
    end
  end

endmodule : adc_serial_readout_iface

// ### adc_host_model.sv
// Behavioural host for the serial readout: drives the pins, clocks frames, captures bits.
// Assumes the bench calls pins and frame one at a time; serial clock idles low.
`timescale 1ns/100ps

module adc_host_model (
  input wire logic clock, // Core clock, paces pin changes
  input wire logic serial_out, // Data from the device
  input wire logic serial_out_oe, // Device drive enable
  output logic sdo_line, // Resolved line with pull-up
  output logic convert_start, // Convert-start pin
  output logic serial_in_select, // Serial input pin
  output logic serial_clock, // Host serial clock
  output logic [16:0] rd_word, // Captured bits, right aligned
  output logic rd_stb // Pulse when a frame is captured
);
  // A floating line reads high, as with a pull-up
  assign sdo_line = serial_out_oe ? serial_out : 1'b1;

  initial begin
    convert_start = 1'b0;
    serial_in_select = 1'b1;
    serial_clock = 1'b0;
    rd_word = 17'h00000;
    rd_stb = 1'b0;
  end

  task pins(input logic c, input logic s, input logic k);
    @(negedge clock);
    convert_start = c;
    serial_in_select = s;
    serial_clock = k;
  endtask : pins

  // Link clock runs at 48 ns only inside the frame
  task frame(input int n);
    int i;
    rd_word = 17'h00000;
    for (i = 0; i < n; i++) begin
      serial_clock = 1'b1;
      #22;
      rd_word = {rd_word[15:0], sdo_line};
      #2;
      serial_clock = 1'b0;
      #24;
    end
    rd_stb = 1'b1;
    #1 rd_stb = 1'b0;
  endtask : frame
endmodule : adc_host_model

// ### adc_serial_readout_iface_asserts.sv
// Checker for the serial readout block; sees only the top module's ports.
// Assumes pins are held steady for a few cycles around starts and conversion ends.
`timescale 1ns/100ps
`include "adc_readout_consts.svh"

module adc_serial_readout_iface_asserts #(
  parameter int CONV_TIME_NS = `CONV_TIME_DEF_NS
) (
  input wire logic clock, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic serial_clock, // Host serial clock
  input wire logic convert_start, // Convert-start pin
  input wire logic serial_in_select, // Serial input pin
  input wire logic [`RESULT_BITS-1:0] sample_code, // Analog code
  input wire logic serial_out, // Serial data
  input wire logic serial_out_oe, // Drive enable
  input wire logic sample_hold, // Start pulse
  input wire logic converting, // Conversion phase
  input wire logic powered_down, // Acquisition
  input wire logic conv_done, // End pulse
  input wire logic chain_mode, // Latched mode
  input wire logic done_flag_en // Start bit enabled
);
  localparam int CYC = CONV_TIME_NS / `CORE_CLK_PERIOD_NS;
  logic [11:0] cyc_q;

  // Length of the conversion, counted from the start pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q <= 12'h000;
    end else if (sample_hold) begin
      cyc_q <= 12'h001;
    end else if (converting) begin
      cyc_q <= cyc_q + 12'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_sel_still; $stable(serial_in_select) [*6]; endsequence
  sequence s_pins_still; ($stable(convert_start) && $stable(serial_in_select)) [*5]; endsequence
  sequence s_select_cs;
    $fell(convert_start) && serial_in_select && !converting && !chain_mode;
  endsequence

  property p_mode_pick; s_sel_still ##1 sample_hold |=> chain_mode == !serial_in_select; endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not taken from select");
  // Busy and power levels register one cycle behind the start pulse
  property p_start; sample_hold |-> !serial_out_oe ##1 (converting && !powered_down); endproperty
  a_start: assert property (p_start) else $error("start response wrong");
  property p_conv_len; conv_done |-> cyc_q == CYC; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_end; $fell(converting) |-> conv_done && powered_down; endproperty
  a_end: assert property (p_end) else $error("no power down at end");
  property p_quiet_conv; converting |-> !serial_out_oe; endproperty
  a_quiet_conv: assert property (p_quiet_conv) else $error("output driven in conversion");
  // The flag output follows the end pulse by one cycle
  property p_flag_low;
    conv_done && !chain_mode |=> done_flag_en == ($past(serial_out_oe) && !$past(serial_out));
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("start bit not driven low");
  property p_chain_off; chain_mode |-> !serial_out_oe; endproperty
  a_chain_off: assert property (p_chain_off) else $error("chain mode drives output");
  property p_flag_pick;
    s_pins_still ##1 (conv_done && !chain_mode) |=>
      done_flag_en == !($past(convert_start) && $past(serial_in_select));
  endproperty
  a_flag_pick: assert property (p_flag_pick) else $error("flag choice wrong");
  property p_cnv_float; $rose(convert_start) && serial_out_oe |-> ##[1:6] !serial_out_oe; endproperty
  a_cnv_float: assert property (p_cnv_float) else $error("output not floated");
  property p_frame_open; s_select_cs |-> ##[2:6] serial_out_oe; endproperty
  a_frame_open: assert property (p_frame_open) else $error("frame not opened");
endmodule : adc_serial_readout_iface_asserts

bind adc_serial_readout_iface adc_serial_readout_iface_asserts #(
  .CONV_TIME_NS(CONV_TIME_NS)
) u_asserts (
  .clock(clock), .arst_n(arst_n), .serial_clock(serial_clock), .convert_start(convert_start),
  .serial_in_select(serial_in_select), .sample_code(sample_code), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .sample_hold(sample_hold), .converting(converting),
  .powered_down(powered_down), .conv_done(conv_done), .chain_mode(chain_mode),
  .done_flag_en(done_flag_en)
);

// ### adc_serial_readout_iface_tb_top.sv
// Self-checking bench for the serial readout block with a behavioural host.
// Assumes the default conversion time; expected results queue up for the monitors.
`timescale 1ns/100ps

module adc_serial_readout_iface_tb_top;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] sample_code = 16'h0000;
  logic [15:0] code;
  logic serial_out, serial_out_oe, sample_hold, converting, powered_down, conv_done;
  logic chain_mode, done_flag_en, convert_start, serial_in_select, serial_clock;
  logic sdo_line, rd_stb;
  logic [16:0] rd_word;
  logic [1:0] q_mode[$];
  logic [16:0] q_word[$];
  int err_total = 0;
  int comparisons = 0;
  logic done_seen = 1'b0;
  int seed = 32'h2A644059;

  always #5 clock = ~clock;

  adc_serial_readout_iface uut (
    .clock(clock), .arst_n(arst_n), .serial_clock(serial_clock),
    .convert_start(convert_start), .serial_in_select(serial_in_select),
    .sample_code(sample_code), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .sample_hold(sample_hold), .converting(converting), .powered_down(powered_down),
    .conv_done(conv_done), .chain_mode(chain_mode), .done_flag_en(done_flag_en)
  );

  adc_host_model u_host (
    .clock(clock), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .sdo_line(sdo_line), .convert_start(convert_start), .serial_in_select(serial_in_select),
    .serial_clock(serial_clock), .rd_word(rd_word), .rd_stb(rd_stb)
  );

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // The flag output settles one cycle after the end pulse
  always @(negedge clock) begin
    if (done_seen) begin
      if (q_mode.size() == 0) chk("mode_queue", 17'h00001, 17'h00000);
      else chk("mode_flag", {15'h0000, chain_mode, done_flag_en},
               {15'h0000, q_mode.pop_front()});
    end
    done_seen = (conv_done === 1'b1);
  end

  always @(posedge rd_stb) begin
    chk("frame", rd_word, q_word.size() ? q_word.pop_front() : 17'h1FFFF);
  end

  // Bounded wait on the start pulse or the end pulse
  task wait_sig(input bit done);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clock);
      if ((done ? conv_done : sample_hold) === 1'b1) return;
    end
    err_total++;
    give_verdict;
  endtask : wait_sig

  // ---------------------------------------------------------------
  // One conversion and optional readout
  // ---------------------------------------------------------------
  task run(input logic s0, sr, k0, c1, s1, ch, fl, input int n);
    u_host.pins(1'b0, s0, k0);
    repeat (8) @(negedge clock);
    code = $random(seed);
    sample_code = code;
    q_mode.push_back({ch, fl});
    u_host.pins(1'b1, sr, k0);
    wait_sig(1'b0);
    chk("oe_at_start", {16'h0000, serial_out_oe}, 17'h00000);
    // A later code must not reach the result
    sample_code = $random(seed);
    repeat (8) @(negedge clock);
    chk("busy_phase", {15'h0000, converting, powered_down}, 17'h00002);
    // dip well before the minimum time
    u_host.pins(1'b0, s0, 1'b0);
    repeat (9) @(negedge clock);
    // pins for the rest of the conversion
    u_host.pins(c1, s1, 1'b0);
    wait_sig(1'b1);
    chk("idle_phase", {15'h0000, converting, powered_down}, 17'h00001);
    if (fl && !ch) chk("busy_edge", {16'h0000, sdo_line}, 17'h00000);
    if (n > 0) begin
      if (!fl) u_host.pins(1'b0, 1'b1, 1'b0);
      repeat (6) @(negedge clock);
      q_word.push_back(n == 17 ? {1'b0, code} : {1'b0, code} >> (16 - n));
      u_host.frame(n);
      repeat (6) @(negedge clock);
      if (n >= 16) chk("float_end", {16'h0000, serial_out_oe}, 17'h00000);
    end
    $display("test end: chain %0d flag %0d bits %0d", ch, fl, n);
  endtask : run

  initial begin
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    chk("reset_oe", {16'h0000, serial_out_oe}, 17'h00000);
    chk("reset_pd", {16'h0000, powered_down}, 17'h00001);
    run(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16);
    run(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 17);
    run(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 17);
    run(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    run(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 0);
    run(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 0);
    // Partial frame cut short by the next start
    run(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 5);
    run(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16);
    repeat (4) @(negedge clock);
    give_verdict;
  end
endmodule : adc_serial_readout_iface_tb_top
